// file: design/scc_pkg.sv
// package: constants for the serial controller clock and select timing block
package scc_pkg;

  // ==========================================================================
  // control and format word fields
  // ==========================================================================
  localparam int CTRL_MODE_BIT = 0;
  localparam int FMT_PS_LSB = 8;
  localparam int FMT_PS_MSB = 15;
  localparam int FMT_PHASE_BIT = 16;
  localparam int FMT_POL_BIT = 17;
  localparam int FMT_WIDTH = 32;
  localparam logic [31:0] FMT_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ==========================================================================
  // delay word fields
  // ==========================================================================
  localparam int DLY_C2T_LSB = 0;
  localparam int DLY_C2T_MSB = 7;
  localparam int DLY_T2C_LSB = 8;
  localparam int DLY_T2C_MSB = 15;
  localparam logic [15:0] DLY_RESET = 16'h0000;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 10000;
  localparam int MIN_SCLK_PERIOD_NS = 25;
  localparam int MIN_SCLK_CYCLES =
    (MIN_SCLK_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_EXTRA = 2;
  localparam int SETUP_HOLD_EXTRA = 3;
  localparam int HOLD_EXTRA = 1;

  typedef enum logic [2:0] {
    SCC_IDLE,
    SCC_LEAD,
    SCC_SHIFT,
    SCC_TRAIL,
    SCC_DONE
  } scc_state_t;

endpackage : scc_pkg

// file: design/scc_fifo.sv
// module: small valid/ready fifo used in the transmit and receive paths
`timescale 1ns/100ps
module scc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic ready_q;
  logic push;
  logic pop;

  assign in_ready_o = ready_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // ==========================================================================
  // storage
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // ==========================================================================
  // pointers and fill level
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      // ready kept in a flop so an upstream ready port is a register
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

endmodule : scc_fifo

// file: design/scc_clkgen.sv
// module: prescaled half-period tick generator for the serial clock
`timescale 1ns/100ps
module scc_clkgen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [7:0] prescale_i,
  output logic tick_o
);

  // a full serial period is (prescale+1) bus cycles; ticks mark each half.
  // the count runs over (prescale+1) bus cycles with a tick at half of that, so an odd total still
  // yields halves that differ by at most one bus cycle.
  logic [8:0] cnt_q;
  logic [8:0] half_a;
  logic [8:0] full;

  assign full = {1'b0, prescale_i} + 9'h001;
  assign half_a = full >> 1;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (cnt_q + 9'h001 == full)
      begin
        cnt_q <= '0;
        tick_o <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 9'h001;
        if (cnt_q + 9'h001 == half_a && half_a != '0)
        begin
          tick_o <= 1'b1;
        end
      end
    end
  end

endmodule : scc_clkgen

// file: design/scc_ctrl.sv
// module: serial controller with chip-select delays and prescaled clock
`timescale 1ns/100ps
// Operation
// - controller mode is bit 0 of the control word, clock phase bit 16 of the format word.
// - the serial clock derives from the bus clock via prescale bits 15 to 8.
// - a serial period is (prescale+1) bus cycles; software keeps it at 25 ns or more.
// - clock polarity bit 17 sets the idle level and thus the active edges.
// - both select delay counts sit in a software-written delay word.
// - with phase set the first edge trails select by half a period plus count plus 2.
// - with select hold set that lead grows by one bus cycle to count plus 3.
// - after the last edge select stays active for count plus 1 bus cycles.
// - the serial clock high and low phases are each within one bus cycle of half a period, for either polarity.
module scc_ctrl #(
  parameter int WORD_BITS = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] global_control_reg_i,
  input wire logic [31:0] format_reg_i,
  input wire logic [15:0] delay_reg_i,
  input wire logic select_hold_option_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [WORD_BITS-1:0] tx_data_i,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [WORD_BITS-1:0] rx_data_o,
  output logic serial_clock_pin_o,
  output logic controller_out_line_o,
  input wire logic controller_in_line_i,
  output logic select_n_o,
  output logic busy_o,
  output logic cfg_error_o
);

  logic controller_mode;
  logic phase;
  logic polarity;
  logic [7:0] prescale_field;
  logic [7:0] select_to_clock_count;
  logic [7:0] clock_to_deselect_count;

  // ==========================================================================
  // configuration decode
  // ==========================================================================
  assign controller_mode = global_control_reg_i[scc_pkg::CTRL_MODE_BIT];
  assign phase = format_reg_i[scc_pkg::FMT_PHASE_BIT];
  assign prescale_field =
    format_reg_i[scc_pkg::FMT_PS_MSB:scc_pkg::FMT_PS_LSB];
  assign polarity = format_reg_i[scc_pkg::FMT_POL_BIT];
  assign select_to_clock_count =
    delay_reg_i[scc_pkg::DLY_C2T_MSB:scc_pkg::DLY_C2T_LSB];
  assign clock_to_deselect_count =
    delay_reg_i[scc_pkg::DLY_T2C_MSB:scc_pkg::DLY_T2C_LSB];

  // ==========================================================================
  // fifos
  // ==========================================================================
  logic txf_valid;
  logic txf_ready;
  logic [WORD_BITS-1:0] txf_data;
  logic rxf_in_valid;
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic [WORD_BITS-1:0] rxf_out_data;

  scc_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(txf_valid),
    .out_ready_i(txf_ready),
    .out_data_o(txf_data)
  );

  // ==========================================================================
  // state machine
  // ==========================================================================
  scc_pkg::scc_state_t state_q;
  logic [9:0] wait_q;
  logic [5:0] edge_q;
  logic [WORD_BITS-1:0] sh_q;
  logic [WORD_BITS-1:0] rx_q;
  logic run;
  logic tick;
  logic start;
  logic rx_pop;

  assign run = (state_q == scc_pkg::SCC_LEAD && wait_q == '0)
    || state_q == scc_pkg::SCC_SHIFT;
  assign txf_ready = (state_q == scc_pkg::SCC_IDLE) && controller_mode
    && rxf_in_ready;
  assign rxf_in_valid = (state_q == scc_pkg::SCC_DONE);
  assign start = txf_valid && txf_ready;
  // the head leaves only once it has been shown, so no word is lost
  assign rx_pop = rx_valid_o && rx_ready_i;

  // a word takes 2*WORD_BITS clock edges; this is the last of them
  function automatic logic last_edge(input logic [5:0] cnt);
    return cnt == 6'(2 * WORD_BITS - 1);
  endfunction : last_edge

  scc_clkgen u_clkgen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .prescale_i(prescale_field),
    .tick_o(tick)
  );

  // rx fifo is only entered when it has room (checked before start)
  scc_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rxf_in_valid),
    .in_ready_o(rxf_in_ready),
    .in_data_i(rx_q),
    .out_valid_o(rxf_out_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rxf_out_data)
  );

  // lead counts bus cycles before the half-period phase; phase set waits
  // the extra half period inside the clock generator's first half tick
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= scc_pkg::SCC_IDLE;
      wait_q <= '0;
      edge_q <= '0;
    end
    else
    begin
      case (state_q)
        scc_pkg::SCC_IDLE:
        begin
          if (start)
          begin
            state_q <= scc_pkg::SCC_LEAD;
            // select active now; clock edge after count+2 (+3 with hold)
            // cycles plus half a period from the generator
            if (select_hold_option_i)
            begin
              wait_q <= 10'(select_to_clock_count)
                + 10'(scc_pkg::SETUP_HOLD_EXTRA - 1);
            end
            else
            begin
              wait_q <= 10'(select_to_clock_count)
                + 10'(scc_pkg::SETUP_EXTRA - 1);
            end
            edge_q <= '0;
          end
        end
        scc_pkg::SCC_LEAD:
        begin
          if (wait_q != '0)
          begin
            wait_q <= wait_q - 10'h001;
          end
          else
          begin
            state_q <= scc_pkg::SCC_SHIFT;
          end
        end
        scc_pkg::SCC_SHIFT:
        begin
          if (tick)
          begin
            edge_q <= edge_q + 6'h01;
            if (last_edge(edge_q))
            begin
              state_q <= scc_pkg::SCC_TRAIL;
              wait_q <= 10'(clock_to_deselect_count);
            end
          end
        end
        scc_pkg::SCC_TRAIL:
        begin
          if (wait_q != '0)
          begin
            wait_q <= wait_q - 10'h001;
          end
          else
          begin
            state_q <= scc_pkg::SCC_DONE;
          end
        end
        scc_pkg::SCC_DONE:
        begin
          state_q <= scc_pkg::SCC_IDLE;
        end
        default:
        begin
          state_q <= scc_pkg::SCC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // serial clock and data
  // ==========================================================================
  // every tick in the shift state toggles the pin, giving halves within one bus cycle of each other for either polarity
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      serial_clock_pin_o <= 1'b0;
    end
    else if (state_q == scc_pkg::SCC_SHIFT && tick)
    begin
      serial_clock_pin_o <= ~serial_clock_pin_o;
    end
    else if (state_q == scc_pkg::SCC_IDLE)
    begin
      serial_clock_pin_o <= polarity;
    end
  end

  // phase set: launch on odd-numbered edges (first, third...), sample on
  // even ones; phase clear: data launched before the first edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sh_q <= '0;
      rx_q <= '0;
      controller_out_line_o <= 1'b0;
    end
    else if (start)
    begin
      sh_q <= txf_data;
      if (!phase)
      begin
        controller_out_line_o <= txf_data[WORD_BITS-1];
        sh_q <= {txf_data[WORD_BITS-2:0], 1'b0};
      end
    end
    else if (state_q == scc_pkg::SCC_SHIFT && tick)
    begin
      if (edge_q[0] == phase)
      begin
        rx_q <= {rx_q[WORD_BITS-2:0], controller_in_line_i};
      end
      else if (!last_edge(edge_q))
      begin
        controller_out_line_o <= sh_q[WORD_BITS-1];
        sh_q <= {sh_q[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // select, status and read port registers
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      select_n_o <= 1'b1;
    end
    else
    begin
      select_n_o <= !(start || state_q == scc_pkg::SCC_LEAD
        || state_q == scc_pkg::SCC_SHIFT
        || (state_q == scc_pkg::SCC_TRAIL && wait_q != '0));
    end
  end

  // busy rises with select so no frame is ever seen without it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      cfg_error_o <= 1'b0;
    end
    else
    begin
      busy_o <= start || (state_q != scc_pkg::SCC_IDLE);
      // flags a period shorter than the 25 ns floor
      cfg_error_o <= controller_mode && (int'(prescale_field) + 1
        < scc_pkg::MIN_SCLK_CYCLES);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end
    else
    begin
      rx_valid_o <= rxf_out_valid && !rx_pop;
      rx_data_o <= rxf_out_data;
    end
  end

endmodule : scc_ctrl

// file: dv/scc_ctrl_asserts.sv
// checker: select and serial clock timing of scc_ctrl
`timescale 1ns/100ps
module scc_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] global_control_reg_i,
  input wire logic [31:0] format_reg_i,
  input wire logic [15:0] delay_reg_i,
  input wire logic select_hold_option_i,
  input wire logic serial_clock_pin_o,
  input wire logic select_n_o,
  input wire logic busy_o,
  input wire logic cfg_error_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // helpers
  // ==========================================================================
  logic sclk_q;
  logic sel_q;
  logic [9:0] cnt_q;
  logic [5:0] tog_q;
  wire tog = serial_clock_pin_o != sclk_q;
  wire [9:0] half = ({2'h0, format_reg_i[15:8]} + 10'h001) >> 1;
  wire [9:0] lead = {2'h0, delay_reg_i[7:0]} + 10'h002 + half;
  wire [9:0] trail = {2'h0, delay_reg_i[15:8]} + 10'h001;
  // one count of cycles since the last select fall or clock edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_q <= 1'b0;
      sel_q <= 1'b1;
      cnt_q <= 10'h000;
      tog_q <= 6'h00;
    end
    else
    begin
      sclk_q <= serial_clock_pin_o;
      sel_q <= select_n_o;
      cnt_q <= (tog || (sel_q && !select_n_o)) ? 10'h001 : cnt_q + 10'h001;
      if (sel_q && !select_n_o)
        tog_q <= 6'h00;
      else if (tog && !select_n_o)
        tog_q <= tog_q + 6'h01;
    end
  end
  // ==========================================================================
  // properties
  // ==========================================================================
  property p_idle;
    (select_n_o && !busy_o && $stable(format_reg_i)) [*3]
      |-> serial_clock_pin_o == format_reg_i[17];
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_mode;
    !global_control_reg_i[0] && select_n_o |=> select_n_o;
  endproperty
  a_mode: assert property (p_mode) else $error("frame when off");
  property p_busy;
    !select_n_o |-> busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low in frame");
  property p_cfg;
    1'b1 |=> cfg_error_o == ($past(global_control_reg_i[0])
      && $past(format_reg_i[15:8]) < 8'h02);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg error flag");
  property p_lead;
    tog && !select_n_o && tog_q == 6'h00 && format_reg_i[16]
      && !select_hold_option_i |-> cnt_q == lead;
  endproperty
  a_lead: assert property (p_lead) else $error("select lead");
  property p_lead_hold;
    tog && !select_n_o && tog_q == 6'h00 && format_reg_i[16]
      && select_hold_option_i |-> cnt_q == lead + 10'h001;
  endproperty
  a_lead_hold: assert property (p_lead_hold) else $error("hold lead");
  // half or half plus one accepted for any prescale, to cover odd prescale+1
  property p_half;
    tog && !select_n_o && tog_q != 6'h00
      |-> cnt_q == half || cnt_q == half + 10'h001;
  endproperty
  a_half: assert property (p_half) else $error("half period");
  property p_trail;
    select_n_o && !sel_q && format_reg_i[16] |-> tog_q == 6'h20
      && cnt_q + 10'h001 >= trail && cnt_q <= trail + 10'h001;
  endproperty
  a_trail: assert property (p_trail) else $error("select trail");
endmodule : scc_ctrl_chk

// file: dv/scc_periph.sv
// partner: serial peripheral answering one word per select frame
`timescale 1ns/100ps
module scc_periph (
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  input wire logic pha_i,
  input wire logic [15:0] reply_i,
  output logic miso_o,
  output logic [15:0] got_o
);
  int k = 0;
  logic [15:0] sh = 16'h0000;
  logic [15:0] got = 16'h0000;
  logic miso = 1'b0;
  logic sel_seen = 1'b1;
  assign miso_o = miso;
  assign got_o = got;
  // one process owns the line; a select edge opens or closes the frame
  always @(sclk_i or sel_n_i)
  begin
    if (sel_n_i !== sel_seen)
    begin
      sel_seen = sel_n_i;
      if (sel_n_i === 1'b0)
      begin
        k = 0;
        sh = reply_i;
        // phase clear needs the first bit before any edge
        if (!pha_i)
        begin
          miso = sh[15];
          sh = sh << 1;
        end
      end
      else
        // released line flips so a stale bit cannot pass
        miso = ~miso;
    end
    else if (!sel_n_i)
    begin
      k = k + 1;
      if (k[0] == pha_i)
      begin
        miso = sh[15];
        sh = sh << 1;
      end
      else
        got = {got[14:0], mosi_i};
    end
  end
endmodule : scc_periph

// file: dv/tb_scc_ctrl.sv
// testbench: frames, fifo limits and config flag of scc_ctrl
`timescale 1ns/100ps
module tb_scc_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] ctrl = 32'h0000_0000;
  logic [31:0] fmt = 32'h0000_0000;
  logic [15:0] dly = 16'h0000;
  logic hold = 1'b0;
  logic tx_v = 1'b0;
  logic [15:0] tx_d = 16'h0000;
  logic rx_r = 1'b0;
  logic [15:0] reply = 16'h0000;
  logic tx_r, rx_v, sclk, mosi, miso, sel_n, busy, cerr;
  logic [15:0] rx_d;
  logic [15:0] got;
  int frames = 0;
  int n_fail = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  always @(posedge sel_n) frames++;
  scc_ctrl uut (.clk_i(clk), .rst_i(rst), .global_control_reg_i(ctrl),
    .format_reg_i(fmt), .delay_reg_i(dly), .select_hold_option_i(hold),
    .tx_valid_i(tx_v), .tx_ready_o(tx_r), .tx_data_i(tx_d),
    .rx_valid_o(rx_v), .rx_ready_i(rx_r), .rx_data_o(rx_d),
    .serial_clock_pin_o(sclk), .controller_out_line_o(mosi),
    .controller_in_line_i(miso), .select_n_o(sel_n), .busy_o(busy),
    .cfg_error_o(cerr));
  scc_periph peer (.sclk_i(sclk), .sel_n_i(sel_n), .mosi_i(mosi),
    .pha_i(fmt[16]), .reply_i(reply), .miso_o(miso), .got_o(got));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task results;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task push(input logic [15:0] d);
    tx_d = d;
    tx_v = 1'b1;
    for (int i = 0; i < 100 && !tx_r; i++) @(negedge clk);
    @(negedge clk);
    tx_v = 1'b0;
    @(negedge clk);
  endtask : push
  // rx copy lags the fifo head, so one spare cycle follows each pop
  task pop_chk(input logic [15:0] e);
    for (int i = 0; i < 9000 && !rx_v; i++) @(negedge clk);
    chk("rx word", {rx_v, rx_d}, {1'b1, e});
    rx_r = 1'b1;
    @(negedge clk);
    rx_r = 1'b0;
    @(negedge clk);
  endtask : pop_chk
  // prescale kept at 2 or more so the period stays 25 ns or longer
  task xfer(input logic [7:0] ps, input logic pol, input logic pha,
    input logic hd, input logic [15:0] dl, input logic [15:0] d,
    input logic [15:0] r);
    fmt = {14'h0000, pol, pha, ps, 8'h00};
    dly = dl;
    hold = hd;
    reply = r;
    repeat (4) @(negedge clk);
    push(d);
    pop_chk(r);
    chk("out word", got, d);
  endtask : xfer
  task t_fifo;
    int f0;
    ctrl = 32'h0000_0000;
    fmt = 32'h0001_0300;
    reply = 16'h3C5A;
    dly = 16'h0000;
    hold = 1'b0;
    @(negedge clk);
    for (int i = 0; i < 4; i++) push(16'hB000 + 16'(i));
    tx_v = 1'b1;
    @(negedge clk);
    chk("full off", {tx_r, sel_n}, 2'b01);
    tx_v = 1'b0;
    f0 = frames;
    ctrl = 32'h0000_0001;
    for (int i = 0; i < 900 && frames < f0 + 4; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("frames", frames - f0, 4);
    for (int i = 0; i < 4; i++) pop_chk(16'h3C5A);
    chk("drained", rx_v, 1'b0);
  endtask : t_fifo
  task t_cfg;
    fmt = 32'h0000_0100;
    repeat (2) @(negedge clk);
    chk("cfg short", cerr, 1'b1);
    ctrl = 32'h0000_0000;
    repeat (2) @(negedge clk);
    chk("cfg off", cerr, 1'b0);
    ctrl = 32'h0000_0001;
    fmt = 32'h0000_0200;
    repeat (2) @(negedge clk);
    chk("cfg ok", cerr, 1'b0);
  endtask : t_cfg
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("idle", {sel_n, busy, rx_v, sclk}, 4'h8);
    ctrl = 32'h0000_0001;
    xfer(8'h03, 1'b0, 1'b1, 1'b0, 16'h0000, 16'hA5C3, 16'h5A3C);
    xfer(8'h05, 1'b1, 1'b1, 1'b1, 16'h0203, 16'h8001, 16'h7FFE);
    xfer(8'h03, 1'b0, 1'b0, 1'b0, 16'h0101, 16'h1234, 16'hFEDC);
    xfer(8'h02, 1'b1, 1'b1, 1'b1, 16'h0000, 16'h0F0F, 16'hC3C3);
    xfer(8'hFF, 1'b1, 1'b1, 1'b0, 16'hFFFF, 16'hC001, 16'h0FF0);
    t_fifo;
    t_cfg;
    results;
  end
  initial
  begin
    #400000;
    n_fail++;
    results;
  end
endmodule : tb_scc_ctrl
bind scc_ctrl scc_ctrl_chk chk (.clk_i, .rst_i, .global_control_reg_i,
  .format_reg_i, .delay_reg_i, .select_hold_option_i, .serial_clock_pin_o,
  .select_n_o, .busy_o, .cfg_error_o);
